// File: hw/prsc_top.sv
// What this block does
// R1 - software powers up the bus comparators before relying on 5 V detection
// R2 - 5 V counts as present when bus voltage exceeds the selected threshold
// R3 - detect-method bit set makes the converter use the bus-valid result
// R4 - converter off while 5 V present, unless the override bit is set
// R5 - linear regulators stay on with 5 V present unless software disables them; core and analog ignore their enables here unless the override bit is set
// R6 - software feeds the converter from the intermediate supply with 5 V present
// R7 - software sets core, analog, io offsets to 25 mV below before enabling
// R8 - software keeps regulator targets below the converter target on each rail
// R9 - converter rail uses target alone; regulator rail adds the offset
// R10 - each rail has a lower brownout threshold and flags falling to it; the memory rail threshold here equals its target
// R11 - target is base plus steps; 25 mV steps, memory rail 50 mV
// R12 - core rail base is 800 mV; 26 steps gives 1450 mV
// R13 - memory rail uses 50 mV steps above 1700 mV
// R14 - memory rail disabled after reset, off until its enable is set
// R15 - software sets memory pull-down before enabling the memory regulator
// R16 - software waits 500 us after memory rail enable before continuing
// R17 - memory limiter active after reset; writing 0 removes it
// R18 - intermediate supply selects 4.2/4.1/4.0/3.9 V or battery; 0 is 4.2
// R19 - battery mode outputs measured battery voltage; software needs 3.0-4.2 V battery
// R20 - offset field picks 25 mV below, equal or 25 mV above
// R21 - with 5 V and converter on, core and analog regulators need enables
// R22 - fields hold until rewritten; changes act at once with no commit
//
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module prsc_top import prsc_pkg::*; #(
    parameter int RAMP_CYC = MEM_RAMP_US * CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic bus_above_i,
    input wire logic supply_gt_io_i,
    input wire logic [3:0] rail_below_i,
    input wire logic [12:0] batt_mv_i,
    output logic bus_comparator_power_up_o,
    output logic [2:0] bus_valid_threshold_select_o,
    output logic bus_valid_indication_o,
    output logic converter_en_o,
    output logic [3:0] linear_regulator_en_o,
    output logic [3:0][12:0] rail_mv_o,
    output logic [3:0][12:0] bo_mv_o,
    output logic memory_rail_limiter_enable_o,
    output logic memory_rail_pulldown_o,
    output logic [12:0] supply_mv_o,
    output logic brownout_o
);
    logic [5:0] ctrl_r, ctrl_nxt;
    prsc_rail_t [2:0] rail_r, rail_nxt;
    prsc_mem_t mem_r, mem_nxt;
    logic [2:0] sup_r, sup_nxt;
    logic [3:0] bo_r, bo_nxt;
    logic [15:0] ramp_r, ramp_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic [5:0] sync1_r, sync2_r;
    logic pres_r, pres_nxt, conv_r, conv_nxt;
    logic [3:0] lin_r, lin_nxt;
    logic [3:0][12:0] mv_r, mv_nxt, bmv_r, bmv_nxt;
    logic [12:0] sup_mv_r, sup_mv_nxt;
    logic req, ramp_done;
    logic [31:0] wd, rd, stat;
    logic [12:0] tgt;
    logic [4:0] rail_target_steps;

    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] m;
        m = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                m[8*b+:8] = d[8*b+:8];
            end
        end
        return m;
    endfunction

    function automatic logic [31:0] rword(input prsc_rail_t r);
        logic [31:0] w;
        w = 32'h0;
        w[RL_TRG+:5] = r.rail_target_steps;
        w[RL_OFS+:2] = r.ofs;
        w[RL_LEN] = r.lin_en;
        w[RL_BO+:3] = r.bo;
        return w;
    endfunction

    function automatic prsc_rail_t runpack(input logic [31:0] w);
        prsc_rail_t r;
        r.rail_target_steps = w[RL_TRG+:5];
        r.ofs = w[RL_OFS+:2];
        r.lin_en = w[RL_LEN];
        r.bo = w[RL_BO+:3];
        return r;
    endfunction

    // pins from the analog side, two flops each before use
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
        end else begin
            sync1_r <= {rail_below_i, supply_gt_io_i, bus_above_i};
            sync2_r <= sync1_r;
        end
    end

    assign req = cyc_i && stb_i;
    assign ramp_done = (ramp_r == 16'(RAMP_CYC));

    always_comb begin
        stat = 32'h0;
        stat[ST_PRES] = pres_r;
        stat[ST_CONV] = conv_r;
        stat[ST_LIN+:4] = lin_r;
        stat[ST_BO+:4] = bo_r;
        stat[ST_RAMP] = ramp_done;
        rd = 32'h0;
        case (adr_i)
            A_CTRL5V: rd = {26'h0, ctrl_r};
            A_CORE: rd = rword(rail_r[0]);
            A_ANA: rd = rword(rail_r[1]);
            A_IO: rd = rword(rail_r[2]);
            A_MEM: rd = {21'h0, mem_r.ilim, mem_r.pd, mem_r.lin_en, 3'h0, mem_r.rail_target_steps};
            A_SUP: rd = {29'h0, sup_r};
            A_STAT: rd = stat;
            default: rd = 32'h0;
        endcase
        wd = wmerge(rd, dat_i, sel_i);
    end

    // register file: values stay until rewritten, no commit step
    always_comb begin
        ctrl_nxt = ctrl_r; // R22
        rail_nxt = rail_r;
        mem_nxt = mem_r;
        sup_nxt = sup_r;
        bo_nxt = bo_r;
        dat_nxt = dat_r;
        ack_nxt = req && !ack_r;
        if (req && !ack_r) begin
            dat_nxt = we_i ? 32'h0 : rd;
            if (we_i) begin
                case (adr_i)
                    A_CTRL5V: ctrl_nxt = wd[5:0];
                    A_CORE: rail_nxt[0] = runpack(wd);
                    A_ANA: rail_nxt[1] = runpack(wd);
                    A_IO: rail_nxt[2] = runpack(wd);
                    A_MEM: mem_nxt = {wd[MM_ILIM], wd[MM_PD], wd[MM_LEN], wd[MM_TRG+:5]}; // R17
                    A_SUP: sup_nxt = wd[2:0];
                    // only the written lane may clear flags, other lanes read back the flags themselves
                    A_STAT: bo_nxt = bo_r & ~(dat_i[ST_BO+:4] & {4{sel_i[ST_BO / 8]}});
                    default: ;
                endcase
            end
        end
        // a brownout in the clearing cycle still sticks
        bo_nxt = bo_nxt | sync2_r[5:2]; // R10
        ramp_nxt = !mem_r.lin_en ? 16'h0000 : (ramp_done ? ramp_r : ramp_r + 16'h0001);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL5V_RST;
            for (int i = 0; i < 3; i++) begin
                rail_r[i] <= '{bo: BO_RST, lin_en: 1'b1, ofs: OFS_RST, rail_target_steps: TRG_RST};
            end
            mem_r <= '{ilim: 1'b1, pd: 1'b0, lin_en: 1'b0, rail_target_steps: TRG_RST}; // R14 R17
            sup_r <= SUP_RST;
            bo_r <= 4'h0;
            ramp_r <= 16'h0000;
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
            rail_r <= rail_nxt;
            mem_r <= mem_nxt;
            sup_r <= sup_nxt;
            bo_r <= bo_nxt;
            ramp_r <= ramp_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    // supply control: everything the analog side sees is registered
    always_comb begin
        pres_nxt = ctrl_r[CT_DET] ? (ctrl_r[CT_PWRUP] && sync2_r[0]) : sync2_r[1]; // R2 R3
        conv_nxt = !pres_r || ctrl_r[CT_OVR]; // R4
        for (int i = 0; i < 2; i++) begin
            lin_nxt[i] = (pres_r && !ctrl_r[CT_OVR]) || rail_r[i].lin_en; // R5 R21
        end
        lin_nxt[2] = rail_r[2].lin_en;
        lin_nxt[3] = mem_r.lin_en; // R14
        mv_nxt = '0;
        bmv_nxt = '0;
        tgt = 13'h0;
        rail_target_steps = 5'h0;
        for (int i = 0; i < 4; i++) begin
            rail_target_steps = (i == 3) ? mem_r.rail_target_steps : rail_r[i % 3].rail_target_steps;
            tgt = RAIL_BASE_MV[i] + 13'(rail_target_steps) * RAIL_STEP_MV[i]; // R11 R12 R13
            mv_nxt[i] = tgt;
            if (i == 3) begin
                bmv_nxt[i] = tgt;
                if (!mem_r.lin_en) begin
                    mv_nxt[i] = 13'h0; // R14
                end
            end else begin
                bmv_nxt[i] = tgt - 13'(rail_r[i].bo) * RAIL_STEP_MV[i]; // R10
                // converter rails ignore the offset
                if (!conv_r) begin // R9
                    case (rail_r[i].ofs) // R20
                        OFS_UP: mv_nxt[i] = tgt + OFS_MV;
                        OFS_DN: mv_nxt[i] = tgt - OFS_MV;
                        default: mv_nxt[i] = tgt;
                    endcase
                end
            end
        end
        // codes 5..7 are undefined, fall back to 4.2 V
        case (sup_r) // R18 R19
            3'h0, 3'h1, 3'h2, 3'h3: sup_mv_nxt = SUP_MV[sup_r[1:0]];
            SUP_BATT: sup_mv_nxt = batt_mv_i;
            default: sup_mv_nxt = SUP_MV[0];
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pres_r <= 1'b0;
            conv_r <= 1'b1;
            lin_r <= 4'h0;
            mv_r <= '0;
            bmv_r <= '0;
            sup_mv_r <= 13'h0;
        end else begin
            pres_r <= pres_nxt;
            conv_r <= conv_nxt;
            lin_r <= lin_nxt;
            mv_r <= mv_nxt;
            bmv_r <= bmv_nxt;
            sup_mv_r <= sup_mv_nxt;
        end
    end

    assign dat_o = dat_r;
    assign ack_o = ack_r;
    assign bus_comparator_power_up_o = ctrl_r[CT_PWRUP];
    assign bus_valid_threshold_select_o = ctrl_r[CT_THR+:3];
    assign bus_valid_indication_o = pres_r;
    assign converter_en_o = conv_r;
    assign linear_regulator_en_o = lin_r;
    assign rail_mv_o = mv_r;
    assign bo_mv_o = bmv_r;
    assign memory_rail_limiter_enable_o = mem_r.ilim;
    assign memory_rail_pulldown_o = mem_r.pd;
    assign supply_mv_o = sup_mv_r;
    assign brownout_o = |bo_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_single_a: assert property (ack_o |=> !ack_o) else $error("ack held two cycles");
    ack_timely_a: assert property (req && !ack_o |=> ack_o) else $error("no ack one cycle after request");
    conv_default_a: assert property (pres_r && !ctrl_r[CT_OVR] |=> !converter_en_o) else $error("converter on"); // R4
    lin_default_a: assert property (pres_r && !ctrl_r[CT_OVR] |=> &linear_regulator_en_o[1:0]) // R5
        else $error("core or analog regulator off");
    detect_bus_a: assert property (ctrl_r[CT_DET] && !ctrl_r[CT_PWRUP] |=> !bus_valid_indication_o) // R3
        else $error("present without comparators");
    mem_off_a: assert property (!mem_r.lin_en |=> rail_mv_o[3] == 13'h0 && !linear_regulator_en_o[3]) // R14
        else $error("memory rail output while disabled");
    core_1450_a: assert property (conv_r && rail_r[0].rail_target_steps == 5'h1A |=> rail_mv_o[0] == 13'h05AA) // R12
        else $error("core target wrong");
    mem_1800_a: assert property (mem_r.lin_en && mem_r.rail_target_steps == 5'h02 |=> rail_mv_o[3] == 13'h0708) // R13
        else $error("memory target wrong");
    offset_dn_a: assert property (!conv_r && rail_r[0].ofs == OFS_DN && rail_r[0].rail_target_steps == 5'h1A // R9
        |=> rail_mv_o[0] == 13'h0591) else $error("core offset below wrong");
    offset_up_a: assert property (!conv_r && rail_r[0].ofs == OFS_UP && rail_r[0].rail_target_steps == 5'h1A // R20
        |=> rail_mv_o[0] == 13'h05C3) else $error("core offset above wrong");
    conv_ovr_a: assert property (ctrl_r[CT_OVR] |=> converter_en_o) // R4
        else $error("override ignored");
    lin_ovr_a: assert property (pres_r && ctrl_r[CT_OVR] && !rail_r[0].lin_en |=> !linear_regulator_en_o[0]) // R21
        else $error("core regulator on without enable");
    io_lin_a: assert property (rail_r[2].lin_en |=> linear_regulator_en_o[2]) // R5
        else $error("io regulator off");
    bo_margin_a: assert property (rail_r[0].bo == 3'h4 && rail_r[0].rail_target_steps == 5'h1A |=> bo_mv_o[0] == 13'h0546) // R10
        else $error("core brownout threshold wrong");
    sup_batt_a: assert property (sup_r == SUP_BATT |=> supply_mv_o == $past(batt_mv_i)) // R19
        else $error("supply not following battery");
    bo_sticky_a: assert property (sync2_r[2] |=> bo_r[0]) else $error("brownout not caught"); // R10
    sup_42_a: assert property (sup_r == 3'h0 |=> supply_mv_o == 13'h1068) else $error("supply not 4.2 V"); // R18
    ilim_reset_a: assert property ($fell(rst_i) |-> memory_rail_limiter_enable_o) else $error("limiter off"); // R17
endmodule // prsc_top

// File: hw/prsc_pkg.sv
package prsc_pkg;
    // register byte addresses
    localparam logic [4:0] A_CTRL5V = 5'h00;
    localparam logic [4:0] A_CORE = 5'h04;
    localparam logic [4:0] A_ANA = 5'h08;
    localparam logic [4:0] A_IO = 5'h0C;
    localparam logic [4:0] A_MEM = 5'h10;
    localparam logic [4:0] A_SUP = 5'h14;
    localparam logic [4:0] A_STAT = 5'h18;
    // 5 V control fields
    localparam int CT_PWRUP = 0;
    localparam int CT_THR = 1;
    localparam int CT_DET = 4;
    localparam int CT_OVR = 5;
    // core/analog/io rail fields
    localparam int RL_TRG = 0;
    localparam int RL_OFS = 8;
    localparam int RL_LEN = 12;
    localparam int RL_BO = 16;
    // memory rail fields
    localparam int MM_TRG = 0;
    localparam int MM_LEN = 8;
    localparam int MM_PD = 9;
    localparam int MM_ILIM = 10;
    // status fields
    localparam int ST_PRES = 0;
    localparam int ST_CONV = 1;
    localparam int ST_LIN = 4;
    localparam int ST_BO = 8;
    localparam int ST_RAMP = 12;
    // reset values
    localparam logic [5:0] CTRL5V_RST = 6'h00;
    localparam logic [4:0] TRG_RST = 5'h00;
    localparam logic [1:0] OFS_RST = 2'h0;
    localparam logic [2:0] BO_RST = 3'h0;
    localparam logic [2:0] SUP_RST = 3'h0;
    // offset codes: equal, 25 mV above, 25 mV below
    localparam logic [1:0] OFS_EQ = 2'h0;
    localparam logic [1:0] OFS_UP = 2'h1;
    localparam logic [1:0] OFS_DN = 2'h2;
    localparam logic [12:0] OFS_MV = 13'h019;
    // supply codes 0..3 are 4.2/4.1/4.0/3.9 V, 4 follows the battery
    localparam logic [2:0] SUP_BATT = 3'h4;
    localparam logic [3:0][12:0] SUP_MV = {13'h0F3C, 13'h0FA0, 13'h1004, 13'h1068};
    // index 0 core, 1 analog, 2 io, 3 memory
    localparam logic [3:0][12:0] RAIL_BASE_MV = {13'h06A4, 13'h0AF0, 13'h05DC, 13'h0320};
    localparam logic [3:0][12:0] RAIL_STEP_MV = {13'h0032, 13'h0019, 13'h0019, 13'h0019};
    // memory rail ramp time
    localparam int MEM_RAMP_US = 500;
    localparam int CLK_MHZ = 40;

    typedef struct packed {
        logic [2:0] bo;
        logic lin_en;
        logic [1:0] ofs;
        logic [4:0] rail_target_steps;
    } prsc_rail_t;

    typedef struct packed {
        logic ilim;
        logic pd;
        logic lin_en;
        logic [4:0] rail_target_steps;
    } prsc_mem_t;
endpackage

// File: verif/prsc_top_tb_top.sv
`timescale 1ns/1ps
module prsc_top_tb_top import prsc_pkg::*;;
    localparam int RAMP = 20;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] dat = 32'h0, q;
    logic bus_above_i = 1'b0, supply_gt_io_i = 1'b0;
    logic [3:0] rail_below_i = 4'h0;
    logic [12:0] batt_mv_i = 13'h0E74;
    logic [31:0] dat_o;
    logic ack_o, pwr_o, pres_o, conv_o, lim_o, pd_o, bo_o;
    logic [2:0] thr_o;
    logic [3:0] lin_o;
    logic [3:0][12:0] mv_o, bomv_o;
    logic [12:0] sup_o;
    int n_errors = 0, samples_checked = 0;

    prsc_top #(.RAMP_CYC(RAMP)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .bus_above_i(bus_above_i),
        .supply_gt_io_i(supply_gt_io_i), .rail_below_i(rail_below_i), .batt_mv_i(batt_mv_i),
        .bus_comparator_power_up_o(pwr_o), .bus_valid_threshold_select_o(thr_o),
        .bus_valid_indication_o(pres_o), .converter_en_o(conv_o), .linear_regulator_en_o(lin_o),
        .rail_mv_o(mv_o), .bo_mv_o(bomv_o), .memory_rail_limiter_enable_o(lim_o),
        .memory_rail_pulldown_o(pd_o), .supply_mv_o(sup_o), .brownout_o(bo_o));

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // classic cycle: hold everything until ack is sampled, then release for a cycle
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        if (k >= 50) chk("wb_ack", 32'h1, {31'h0, ack_o});
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hF);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic t_reset();
        chk("lim_rst", 32'h1, 32'(lim_o));
        chk("mem_lin_rst", 32'h0, 32'(lin_o[3]));
        chk("mem_mv_rst", 32'h0, 32'(mv_o[3]));
        wb(1'b0, A_MEM, 32'h0, 4'hF);
        chk("mem_reg_rst", 32'h0000_0400, q);
        wb(1'b0, A_CORE, 32'h0, 4'hF);
        chk("core_reg_rst", 32'h0000_1000, q);
        wb(1'b0, 5'h1C, 32'h0, 4'hF);
        chk("unmapped", 32'h0, q);
    endtask

    task automatic t_detect();
        @(posedge clk_i);
        bus_above_i <= 1'b1;
        wr(A_CTRL5V, 32'h0000_0013);
        tick(6);
        chk("pwrup", 32'h1, 32'(pwr_o));
        chk("thr", 32'h1, 32'(thr_o));
        chk("present", 32'h1, 32'(pres_o));
        chk("conv_off", 32'h0, 32'(conv_o));
        // converter feed and contention offsets go in before any override
        wr(A_SUP, 32'h0000_0000);
        wr(A_ANA, 32'h0000_1200);
        wr(A_IO, 32'h0000_1200);
        wr(A_CORE, 32'h0000_0200);
        tick(6);
        chk("lin_default", 32'h1, 32'(lin_o[0]));
        wr(A_CTRL5V, 32'h0000_0033);
        tick(6);
        chk("conv_ovr", 32'h1, 32'(conv_o));
        chk("core_lin_off", 32'h0, 32'(lin_o[0]));
        chk("ana_lin_on", 32'h1, 32'(lin_o[1]));
        wr(A_CTRL5V, 32'h0000_0012);
        tick(6);
        chk("no_pwrup", 32'h0, 32'(pres_o));
        wr(A_CTRL5V, 32'h0000_0013);
        tick(6);
        chk("present_again", 32'h1, 32'(pres_o));
        wr(A_CTRL5V, 32'h0000_0003);
        tick(6);
        chk("other_method", 32'h0, 32'(pres_o));
    endtask

    task automatic t_target();
        logic [1:0] oc[3] = '{OFS_EQ, OFS_UP, OFS_DN};
        logic [12:0] base;
        logic [12:0] exp_mv;
        base = RAIL_BASE_MV[0] + 13'h01A * RAIL_STEP_MV[0];
        wr(A_CTRL5V, 32'h0000_0033);
        wr(A_CORE, 32'h0000_121A);
        tick(6);
        chk("core_dcdc_mv", 32'h5AA, 32'(mv_o[0]));
        wr(A_CTRL5V, 32'h0000_0013);
        for (int i = 0; i < 3; i++) begin
            wr(A_CORE, 32'h0000_101A | (32'(oc[i]) << RL_OFS));
            tick(6);
            exp_mv = base + (i == 1 ? OFS_MV : 13'h0) - (i == 2 ? OFS_MV : 13'h0);
            chk("core_lin_mv", 32'(exp_mv), 32'(mv_o[0]));
        end
        chk("ana_mv", 32'(RAIL_BASE_MV[1] - OFS_MV), 32'(mv_o[1]));
        wr(A_IO, 32'h0000_1004);
        tick(6);
        chk("io_mv", 32'(RAIL_BASE_MV[2] + 13'h004 * RAIL_STEP_MV[2]), 32'(mv_o[2]));
    endtask

    task automatic t_mem();
        wr(A_MEM, 32'h0000_0602);
        wr(A_MEM, 32'h0000_0702);
        wb(1'b0, A_STAT, 32'h0, 4'hF);
        chk("ramp_early", 32'h0, 32'(q[ST_RAMP]));
        tick(RAMP + 5);
        wb(1'b0, A_STAT, 32'h0, 4'hF);
        chk("ramp_done", 32'h1, 32'(q[ST_RAMP]));
        chk("mem_mv", 32'h708, 32'(mv_o[3]));
        chk("mem_lin", 32'h1, 32'(lin_o[3]));
        chk("mem_pd", 32'h1, 32'(pd_o));
        chk("lim_kept", 32'h1, 32'(lim_o));
        wr(A_MEM, 32'h0000_0302);
        tick(3);
        chk("lim_off", 32'h0, 32'(lim_o));
    endtask

    task automatic t_supply();
        for (int c = 0; c < 6; c++) begin
            wr(A_SUP, 32'(c));
            tick(3);
            chk("supply_mv", 32'(c < 4 ? SUP_MV[c] : (c == 4 ? batt_mv_i : SUP_MV[0])), 32'(sup_o));
        end
    endtask

    task automatic t_brown();
        wr(A_CORE, 32'h0004_101A);
        tick(6);
        chk("bo_mv", 32'h546, 32'(bomv_o[0]));
        @(posedge clk_i);
        rail_below_i <= 4'h1;
        tick(6);
        chk("bo_set", 32'h1, 32'(bo_o));
        @(posedge clk_i);
        rail_below_i <= 4'h0;
        tick(4);
        chk("bo_sticky", 32'h1, 32'(bo_o));
        wr(A_STAT, 32'h0000_0100);
        tick(3);
        chk("bo_clear", 32'h0, 32'(bo_o));
        @(posedge clk_i);
        rail_below_i <= 4'h2;
        tick(6);
        @(posedge clk_i);
        rail_below_i <= 4'h0;
        tick(4);
        wb(1'b1, A_STAT, 32'h0000_0200, 4'h1);
        tick(2);
        chk("bo_lane_kept", 32'h1, 32'(bo_o));
        wb(1'b1, A_CORE, 32'h0000_0005, 4'h1);
        wb(1'b0, A_CORE, 32'h0, 4'hF);
        chk("byte_lane", 32'h0004_1005, q);
    endtask

    initial begin
        repeat (4000) @(posedge clk_i);
        n_errors++;
        results();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        tick(2);
        t_reset();
        t_detect();
        t_target();
        t_mem();
        t_supply();
        t_brown();
        results();
    end
endmodule // prsc_top_tb_top
